// *** design/spe_defines.svh ***
`ifndef SPE_DEFINES_SVH
`define SPE_DEFINES_SVH

// ----------------------------------------
// Key and serial word layout
// ----------------------------------------
// Entry key value is arbitrary
`define SPE_KEY_W 32
`define SPE_ENTRY_KEY 32'hA5C3_3C5A
`define SPE_WORD_W 16
`define SPE_BIT_CNT_W 4
`define SPE_BIT_LAST 4'hF
`define SPE_BIT_ZERO 4'h0
`define SPE_WORD_ZERO 16'h0000
`define SPE_KEY_ZERO 32'h0000_0000

// ----------------------------------------
// Synchroniser depth
// ----------------------------------------
`define SPE_SYNC_W 2

`endif

// *** design/spe_entry.sv ***
// Overview of operation
// RQ1: Serial clock is clock; data pin bidirectional.
// RQ2: Program session accepts serial words for programming.
// RQ3: Clock, data low then high voltage enters.
// RQ4: Key entry only when enable bit is one.
// RQ5: Programmer drives clear low, shifts 32-bit key.
// RQ6: Programmer holds clear low whole session.
// RQ7: Enable bit forces clear reset function on.
// RQ8: Enable bit cleared only in high-voltage session.
// RQ9: Wrong key: no entry, reset stays held.
`timescale 1ns/1ps
`default_nettype none
`include "spe_defines.svh"

module spe_entry (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data_in,
  output logic prog_serial_data_out,
  output logic prog_serial_data_oe_out,
  input wire logic master_clear_pin_in,
  input wire logic master_clear_hv_in,
  input wire logic low_voltage_entry_enable_in,
  input wire logic master_clear_func_cfg_in,
  input wire logic lve_clear_req_in,
  input wire logic verify_en_in,
  input wire logic [`SPE_WORD_W-1:0] verify_word_in,
  output logic [`SPE_WORD_W-1:0] prog_word_out,
  output logic prog_word_valid_out,
  output logic prog_mode_out,
  output logic hv_session_out,
  output logic lv_session_out,
  output logic low_voltage_entry_enable_out,
  output logic device_reset_out
);

  // ----------------------------------------
  // System domain synchronisers
  // ----------------------------------------
  spe_pkg::spe_pins_s pins_raw;
  spe_pkg::spe_pins_s pins_s1_q;
  spe_pkg::spe_pins_s pins_s2_q;
  logic match_s1_q;
  logic match_s2_q;
  logic match_s3_q;
  logic wtog_s1_q;
  logic wtog_s2_q;
  logic wtog_s3_q;
  spe_pkg::spe_state_e state_q;
  spe_pkg::spe_state_e state_d;
  logic key_match_q;
  logic word_tog_q;
  logic [`SPE_WORD_W-1:0] rx_hold_q;

  assign pins_raw = '{master_clear_pin_n: master_clear_pin_in, hv: master_clear_hv_in,
                      sclk: prog_serial_clock, sdat: prog_serial_data_in};

  always_ff @(posedge clk_in) begin
    pins_s1_q <= pins_raw;
    pins_s2_q <= pins_s1_q;
    match_s1_q <= key_match_q;
    match_s2_q <= match_s1_q;
    match_s3_q <= match_s2_q;
    wtog_s1_q <= word_tog_q;
    wtog_s2_q <= wtog_s1_q;
    wtog_s3_q <= wtog_s2_q;
  end

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  spe_pkg::spe_cfg_s cfg_q;
  spe_pkg::spe_cfg_s cfg_d;
  logic cfg_loaded_q;
  logic lve_clear_ok;

  assign lve_clear_ok = lve_clear_req_in && (state_q == spe_pkg::SPE_ST_HV_PROG); // RQ8

  always_comb begin
    cfg_d = cfg_q;
    if (!cfg_loaded_q) begin
      cfg_d.lve = low_voltage_entry_enable_in;
    end else if (lve_clear_ok) begin
      cfg_d.lve = 1'b0; // RQ8
    end
    cfg_d.master_clear_pin_func = master_clear_func_cfg_in || cfg_d.lve; // RQ7
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cfg_q <= '{lve: 1'b0, master_clear_pin_func: 1'b1};
      cfg_loaded_q <= 1'b0;
    end else begin
      cfg_q <= cfg_d;
      cfg_loaded_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Entry state machine
  // ----------------------------------------
  logic hv_q;
  logic in_prog;
  logic sess_start;
  logic sess_tog_q;
  logic hv_rise;
  logic hv_pins_quiet;
  logic key_seen;

  assign hv_rise = pins_s2_q.hv && !hv_q;
  assign hv_pins_quiet = !pins_s2_q.sclk && !pins_s2_q.sdat;
  assign key_seen = match_s2_q && !match_s3_q;
  assign sess_start = !in_prog && ((state_d == spe_pkg::SPE_ST_HV_PROG) ||
                                   (state_d == spe_pkg::SPE_ST_LV_PROG));

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      spe_pkg::SPE_ST_RUN: begin
        if (hv_rise && hv_pins_quiet) begin
          state_d = spe_pkg::SPE_ST_HV_PROG; // RQ3
        end else if (cfg_q.lve && !pins_s2_q.master_clear_pin_n) begin
          state_d = spe_pkg::SPE_ST_LV_ARM; // RQ4
        end
      end
      spe_pkg::SPE_ST_LV_ARM: begin
        if (hv_rise && hv_pins_quiet) begin
          state_d = spe_pkg::SPE_ST_HV_PROG; // RQ3
        end else if (pins_s2_q.master_clear_pin_n || !cfg_q.lve) begin
          state_d = spe_pkg::SPE_ST_RUN;
        end else if (key_seen) begin
          state_d = spe_pkg::SPE_ST_LV_PROG; // RQ9
        end
      end
      spe_pkg::SPE_ST_HV_PROG: begin
        if (!pins_s2_q.hv) begin
          state_d = spe_pkg::SPE_ST_RUN;
        end
      end
      spe_pkg::SPE_ST_LV_PROG: begin
        if (pins_s2_q.master_clear_pin_n) begin
          state_d = spe_pkg::SPE_ST_RUN; // RQ6
        end
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= spe_pkg::SPE_ST_RUN;
      hv_q <= 1'b0;
      sess_tog_q <= 1'b0;
    end else begin
      state_q <= state_d;
      hv_q <= pins_s2_q.hv;
      sess_tog_q <= sess_tog_q ^ sess_start;
    end
  end

  // ----------------------------------------
  // Session and reset outputs
  // ----------------------------------------
  logic reset_d;
  logic reset_q;

  assign in_prog = (state_q == spe_pkg::SPE_ST_HV_PROG) ||
                   (state_q == spe_pkg::SPE_ST_LV_PROG);
  assign reset_d = in_prog || (cfg_q.master_clear_pin_func && !pins_s2_q.master_clear_pin_n); // RQ7 RQ9

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reset_q <= 1'b1;
    end else begin
      reset_q <= reset_d;
    end
  end

  assign prog_mode_out = in_prog;
  assign hv_session_out = (state_q == spe_pkg::SPE_ST_HV_PROG);
  assign lv_session_out = (state_q == spe_pkg::SPE_ST_LV_PROG);
  assign low_voltage_entry_enable_out = cfg_q.lve;
  assign device_reset_out = reset_q;

  // ----------------------------------------
  // Received words into system domain
  // ----------------------------------------
  logic [`SPE_WORD_W-1:0] word_q;
  logic word_valid_q;
  logic word_new;

  assign word_new = (wtog_s2_q != wtog_s3_q) && in_prog; // RQ2

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      word_q <= `SPE_WORD_ZERO;
      word_valid_q <= 1'b0;
    end else begin
      word_valid_q <= word_new;
      if (word_new) begin
        word_q <= rx_hold_q;
      end
    end
  end

  assign prog_word_out = word_q;
  assign prog_word_valid_out = word_valid_q;

  // ----------------------------------------
  // Levels into the link domain
  // ----------------------------------------
  logic verify_q;
  logic [`SPE_WORD_W-1:0] verify_word_q;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      verify_q <= 1'b0;
      verify_word_q <= `SPE_WORD_ZERO;
    end else begin
      verify_q <= verify_en_in && in_prog;
      if (!verify_q) begin
        verify_word_q <= verify_word_in;
      end
    end
  end

  // ----------------------------------------
  // Link domain, clocked by the serial clock
  // ----------------------------------------
  logic [`SPE_SYNC_W-1:0] lrst_q;
  logic [`SPE_SYNC_W-1:0] lprog_q;
  logic [`SPE_SYNC_W-1:0] lver_q;
  logic [`SPE_SYNC_W:0] lsess_q;
  logic [`SPE_KEY_W-1:0] key_sh_q;
  logic [`SPE_BIT_CNT_W-1:0] bit_cnt_q;
  logic [`SPE_WORD_W-1:0] rx_sh_q;
  logic [`SPE_WORD_W-1:0] tx_sh_q;
  logic tx_oe_q;
  logic link_rst;
  logic link_prog;
  logic link_ver;
  logic link_new;
  logic word_end;
  logic [`SPE_KEY_W-1:0] key_next;
  logic [`SPE_WORD_W-1:0] rx_next;

  assign link_rst = lrst_q[1];
  assign link_prog = lprog_q[1];
  assign link_ver = lver_q[1];
  assign link_new = lsess_q[2] ^ lsess_q[1];
  assign word_end = (bit_cnt_q == `SPE_BIT_LAST);
  assign key_next = {key_sh_q[`SPE_KEY_W-2:0], prog_serial_data_in}; // RQ5
  assign rx_next = {rx_sh_q[`SPE_WORD_W-2:0], prog_serial_data_in};
  always_ff @(posedge prog_serial_clock) begin // RQ1
    lrst_q <= {lrst_q[0], rst_in};
    lprog_q <= {lprog_q[0], in_prog};
    lver_q <= {lver_q[0], verify_q};
    lsess_q <= {lsess_q[`SPE_SYNC_W-1:0], sess_tog_q};
  end
  always_ff @(posedge prog_serial_clock) begin
    if (link_rst) begin
      key_sh_q <= `SPE_KEY_ZERO;
      key_match_q <= 1'b0;
    end else begin
      key_sh_q <= key_next; // RQ5
      key_match_q <= (key_next == `SPE_ENTRY_KEY) && !link_prog; // RQ9
    end
  end

  always_ff @(posedge prog_serial_clock) begin
    if (link_rst || !link_prog) begin
      bit_cnt_q <= `SPE_BIT_ZERO;
      rx_sh_q <= `SPE_WORD_ZERO;
      rx_hold_q <= `SPE_WORD_ZERO;
      word_tog_q <= 1'b0;
      tx_sh_q <= `SPE_WORD_ZERO;
      tx_oe_q <= 1'b0;
    end else begin
      bit_cnt_q <= (link_new ? `SPE_BIT_ZERO : bit_cnt_q) + 4'h1;
      rx_sh_q <= rx_next;
      if (link_new || (bit_cnt_q == `SPE_BIT_ZERO)) begin
        tx_oe_q <= link_ver; // RQ1
        tx_sh_q <= verify_word_q;
      end else begin
        tx_sh_q <= {tx_sh_q[`SPE_WORD_W-2:0], 1'b0};
      end
      if (word_end && !tx_oe_q && !link_new) begin
        rx_hold_q <= rx_next; // RQ2
        word_tog_q <= !word_tog_q;
      end
    end
  end

  assign prog_serial_data_out = tx_sh_q[`SPE_WORD_W-1];
  assign prog_serial_data_oe_out = tx_oe_q; // RQ1

endmodule

`default_nettype wire

// *** design/spe_pkg.sv ***
`include "spe_defines.svh"

package spe_pkg;

  // ----------------------------------------
  // Entry and session states
  // ----------------------------------------
  typedef enum logic [3:0] {
    SPE_ST_RUN     = 4'b0001,
    SPE_ST_LV_ARM  = 4'b0010,
    SPE_ST_HV_PROG = 4'b0100,
    SPE_ST_LV_PROG = 4'b1000
  } spe_state_e;

  // ----------------------------------------
  // Pin levels seen in the system domain
  // ----------------------------------------
  typedef struct packed {
    logic master_clear_pin_n;
    logic hv;
    logic sclk;
    logic sdat;
  } spe_pins_s;

  // ----------------------------------------
  // Configuration seen by the entry logic
  // ----------------------------------------
  typedef struct packed {
    logic lve;
    logic master_clear_pin_func;
  } spe_cfg_s;

endpackage

// *** tb/spe_entry_props.sv ***
`timescale 1ns/1ps
`default_nettype none
module spe_entry_props (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic prog_serial_clock,
  input wire logic prog_serial_data_in,
  input wire logic master_clear_pin_in,
  input wire logic master_clear_hv_in,
  input wire logic prog_word_valid_out,
  input wire logic prog_mode_out,
  input wire logic hv_session_out,
  input wire logic lv_session_out,
  input wire logic low_voltage_entry_enable_out,
  input wire logic device_reset_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  property p_mode;
    prog_mode_out == (hv_session_out | lv_session_out) && !(hv_session_out && lv_session_out);
  endproperty
  property p_hv;
    (!prog_serial_clock && !prog_serial_data_in)[*3] ##0
      ($rose(master_clear_hv_in) && !prog_mode_out) |-> ##[1:5] hv_session_out;
  endproperty
  property p_hvend;
    (!master_clear_hv_in)[*4] |-> !hv_session_out;
  endproperty
  property p_lv;
    $rose(lv_session_out) |-> low_voltage_entry_enable_out && !master_clear_pin_in;
  endproperty
  property p_rst;
    (low_voltage_entry_enable_out && !master_clear_pin_in)[*5] |-> device_reset_out;
  endproperty
  property p_clr;
    low_voltage_entry_enable_out && !hv_session_out |=> low_voltage_entry_enable_out;
  endproperty
  property p_valid;
    prog_word_valid_out |-> prog_mode_out ##1 !prog_word_valid_out;
  endproperty
  a_mode: assert property (p_mode) else $error("session flags");
  a_hv: assert property (p_hv) else $error("no hv entry");
  a_hvend: assert property (p_hvend) else $error("hv kept");
  a_lv: assert property (p_lv) else $error("lv entry");
  a_rst: assert property (p_rst) else $error("reset not held");
  a_clr: assert property (p_clr) else $error("enable lost");
  a_valid: assert property (p_valid) else $error("word pulse");
  c_hv: cover property ($rose(hv_session_out));
  c_lv: cover property ($rose(lv_session_out));
  c_word: cover property (prog_word_valid_out);
endmodule
`default_nettype wire

// *** tb/spe_prog_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module spe_prog_model (
  input wire logic data_in,
  input wire logic data_oe_in,
  output logic sclk_out,
  output var logic sdat_out,
  output logic master_clear_pin_n_out,
  output logic hv_out
);
  logic drv;
  assign sdat_out = data_oe_in ? data_in : drv;
  initial begin
    sclk_out = 1'b0;
    drv = 1'b0;
    master_clear_pin_n_out = 1'b1;
    hv_out = 1'b0;
  end
  // Clock pulses outside frames, data line left at drv
  task automatic pulse(input int n);
    repeat (n) begin
      #8 sclk_out = 1'b1;
      #16 sclk_out = 1'b0;
      #8;
    end
  endtask
  // MSB first, read back on falling edge
  task automatic shift(input logic [31:0] v, output logic [31:0] rd);
    for (int i = 31; i >= 0; i--) begin
      drv = v[i];
      #8 sclk_out = 1'b1;
      #16 sclk_out = 1'b0;
      rd[i] = sdat_out;
      #8;
    end
    drv = 1'b0;
  endtask
  task automatic pins(input logic m, input logic h);
    master_clear_pin_n_out = m;
    hv_out = h;
  endtask
endmodule
`default_nettype wire

// *** tb/test_serial_programming_entry.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spe_defines.svh"
module test_serial_programming_entry;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic low_voltage_entry_enable_in = 1'b1;
  logic master_clear_func_cfg_in = 1'b0;
  logic lve_clear_req_in = 1'b0;
  logic verify_en_in = 1'b0;
  logic [`SPE_WORD_W-1:0] verify_word_in = 16'hC35A;
  wire prog_serial_clock, prog_serial_data_in, master_clear_pin_in, master_clear_hv_in;
  wire prog_serial_data_out, prog_serial_data_oe_out, prog_word_valid_out, prog_mode_out;
  wire hv_session_out, lv_session_out, low_voltage_entry_enable_out, device_reset_out;
  wire [`SPE_WORD_W-1:0] prog_word_out;
  int fails = 0;
  int total_checks = 0;
  int words = 0;
  logic [31:0] rd;
  spe_entry spe_entry_inst (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .prog_serial_clock(prog_serial_clock),
    .prog_serial_data_in(prog_serial_data_in),
    .prog_serial_data_out(prog_serial_data_out),
    .prog_serial_data_oe_out(prog_serial_data_oe_out),
    .master_clear_pin_in(master_clear_pin_in),
    .master_clear_hv_in(master_clear_hv_in),
    .low_voltage_entry_enable_in(low_voltage_entry_enable_in),
    .master_clear_func_cfg_in(master_clear_func_cfg_in),
    .lve_clear_req_in(lve_clear_req_in),
    .verify_en_in(verify_en_in),
    .verify_word_in(verify_word_in),
    .prog_word_out(prog_word_out),
    .prog_word_valid_out(prog_word_valid_out),
    .prog_mode_out(prog_mode_out),
    .hv_session_out(hv_session_out),
    .lv_session_out(lv_session_out),
    .low_voltage_entry_enable_out(low_voltage_entry_enable_out),
    .device_reset_out(device_reset_out)
  );
  spe_prog_model spe_prog_model_inst (
    .data_in(prog_serial_data_out),
    .data_oe_in(prog_serial_data_oe_out),
    .sclk_out(prog_serial_clock),
    .sdat_out(prog_serial_data_in),
    .master_clear_pin_n_out(master_clear_pin_in),
    .hv_out(master_clear_hv_in)
  );
  always #5 clk_in = ~clk_in;
  always @(negedge clk_in) if (prog_word_valid_out === 1'b1) words++;
  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string n, input logic [31:0] e, g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic t_lv_bad;
    spe_prog_model_inst.pins(1'b0, 1'b0);
    wt(1);
    lve_clear_req_in = 1'b1;
    wt(10);
    lve_clear_req_in = 1'b0;
    chk("forced reset", 1, device_reset_out);
    chk("enable kept", 1, low_voltage_entry_enable_out);
    spe_prog_model_inst.shift(~`SPE_ENTRY_KEY, rd);
    wt(10);
    chk("bad key mode", 0, prog_mode_out);
    chk("bad key reset", 1, device_reset_out);
  endtask
  task automatic t_lv_good;
    int n;
    spe_prog_model_inst.shift(`SPE_ENTRY_KEY, rd);
    wt(10);
    chk("lv session", 1, lv_session_out);
    spe_prog_model_inst.pulse(2);
    n = words;
    spe_prog_model_inst.shift(32'h1234_ABCD, rd);
    wt(10);
    chk("word", 16'hABCD, prog_word_out);
    chk("word count", n + 2, words);
    spe_prog_model_inst.pins(1'b1, 1'b0);
    wt(10);
    chk("lv end", 0, prog_mode_out);
    chk("reset free", 0, device_reset_out);
  endtask
  task automatic t_hv;
    verify_en_in = 1'b1;
    spe_prog_model_inst.pins(1'b1, 1'b1);
    wt(10);
    chk("hv session", 1, hv_session_out);
    spe_prog_model_inst.pulse(2);
    spe_prog_model_inst.shift(32'h0, rd);
    chk("read back", 32'hC35A_C35A, rd);
    wt(1);
    verify_en_in = 1'b0;
    lve_clear_req_in = 1'b1;
    wt(5);
    lve_clear_req_in = 1'b0;
    chk("enable cleared", 0, low_voltage_entry_enable_out);
    spe_prog_model_inst.pins(1'b1, 1'b0);
    wt(10);
    chk("hv end", 0, prog_mode_out);
  endtask
  task automatic t_lv_off;
    spe_prog_model_inst.pins(1'b0, 1'b0);
    spe_prog_model_inst.shift(`SPE_ENTRY_KEY, rd);
    wt(10);
    chk("key refused", 0, prog_mode_out);
    chk("no forced reset", 0, device_reset_out);
    master_clear_func_cfg_in = 1'b1;
    wt(6);
    chk("cfg reset", 1, device_reset_out);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    fork
      spe_prog_model_inst.pulse(3);
      begin
        wt(2);
        chk("in reset", 1, device_reset_out);
        rst_in = 1'b0;
      end
    join
    wt(3);
    t_lv_bad;
    t_lv_good;
    t_hv;
    t_lv_off;
    wrap_up;
  end
  initial begin
    #100000;
    fails++;
    wrap_up;
  end
endmodule
bind spe_entry spe_entry_props spe_entry_props_inst (
  .clk_in(clk_in),
  .rst_in(rst_in),
  .prog_serial_clock(prog_serial_clock),
  .prog_serial_data_in(prog_serial_data_in),
  .master_clear_pin_in(master_clear_pin_in),
  .master_clear_hv_in(master_clear_hv_in),
  .prog_word_valid_out(prog_word_valid_out),
  .prog_mode_out(prog_mode_out),
  .hv_session_out(hv_session_out),
  .lv_session_out(lv_session_out),
  .low_voltage_entry_enable_out(low_voltage_entry_enable_out),
  .device_reset_out(device_reset_out)
);
`default_nettype wire
